// ### adcsr_consts.svh
// constants, offsets and field positions of the scan result controller
// What this block does
// - twenty-four external input channels, each with its own result register
// - a normal conversion stores a full-accuracy 12-bit result
// - peripheral to conversion clock ratio is 1:1, 1:2, 2:1, 4:1 or 8:1
// - addition mode stores the sum widened by two or four bits
// - double trigger mode works only in single or group scan mode
// - double trigger: first result to channel register, second to duplicate
// - separate result registers for temperature sensor and internal reference
// - one extra result register holds the self-diagnostic conversion
// - single scan converts each selected channel once, then stops
// - group A trigger with A priority aborts a running group B scan
`ifndef ADCSR_CONSTS_SVH
`define ADCSR_CONSTS_SVH

`define ADCSR_OFS_CTRL   8'h00
`define ADCSR_OFS_CHSA   8'h04
`define ADCSR_OFS_CHSB   8'h08
`define ADCSR_OFS_STAT   8'h0C
`define ADCSR_OFS_MASK   8'h10
`define ADCSR_OFS_TRIG   8'h14
`define ADCSR_OFS_RES    8'h40
`define ADCSR_OFS_DUP    8'hAC

`define ADCSR_N_EXT      24
`define ADCSR_N_RES      27
`define ADCSR_DATA_W     12
`define ADCSR_RES_W      16
`define ADCSR_CTRL_W     17

`define ADCSR_ST_W       4
`define ADCSR_ST_DONE_A  0
`define ADCSR_ST_DONE_B  1
`define ADCSR_ST_ABORT   2
`define ADCSR_ST_DUP     3
`define ADCSR_ST_BUSY    8

`define ADCSR_TRIG_A     0
`define ADCSR_TRIG_B     1
`define ADCSR_TRIG_STOP  2

`define ADCSR_MODE_SINGLE 2'h0
`define ADCSR_MODE_CONT   2'h1
`define ADCSR_MODE_GROUP  2'h2

`define ADCSR_RATIO_MAX  3'h4

`define ADCSR_ADD_ONE    5'h01
`define ADCSR_ADD_TWO    5'h04
`define ADCSR_ADD_FOUR   5'h10

`define ADCSR_CONV_NS    830
`define ADCSR_CLK_NS     100
`define ADCSR_CONV_CYC   (`ADCSR_CONV_NS / `ADCSR_CLK_NS)

`endif

// ### adcsr_pkg.sv
// types shared by the scan result controller
package adcsr_pkg;

  typedef enum logic [1:0] {S_IDLE, S_NEXT, S_WAIT, S_STORE} adcsr_state_t;

  // control register layout, bit 0 at the bottom
  typedef struct packed {
    logic       vref_en;
    logic       temp_en;
    logic       diag_en;
    logic [4:0] dbl_ch;
    logic       a_prio;
    logic [2:0] ratio;
    logic       add_wide;
    logic       add_en;
    logic       dbl_en;
    logic [1:0] mode;
  } adcsr_ctrl_t;

  typedef struct packed {
    logic       start;
    logic [4:0] chan;
  } adcsr_conv_req_t;

endpackage

// ### adcsr_pacer.sv
// per-channel conversion timer
`timescale 1ns/1ns
`default_nettype none
`include "adcsr_consts.svh"
module adcsr_pacer (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // control
  input  wire logic start,
  output logic      done
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic       done_reg;
  logic       done_next;

  // a fresh start restarts the count, which is how an abort drops a channel
  always_comb begin
    cnt_next  = cnt_reg;
    done_next = (cnt_reg == 4'h1) & ~start;
    if (start) begin
      cnt_next = 4'(`ADCSR_CONV_CYC);
    end else if (cnt_reg != 4'h0) begin
      cnt_next = cnt_reg - 4'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= 4'h0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;

  AST_PACE: assert property (@(posedge core_clk) disable iff (rst)
    start ##1 (!start)[*8] |=> done)
    else $error("conversion period is not eight cycles");
endmodule
`default_nettype wire

// ### adcsr_accum.sv
// conversion result accumulator for addition mode
`timescale 1ns/1ns
`default_nettype none
`include "adcsr_consts.svh"
module adcsr_accum (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // samples
  input  wire logic                      clr,
  input  wire logic                      add,
  input  wire logic [`ADCSR_DATA_W-1:0]  data,
  output logic      [`ADCSR_RES_W-1:0]   sum
);
  logic [`ADCSR_RES_W-1:0] sum_reg;
  logic [`ADCSR_RES_W-1:0] sum_next;

  // sixteen 12-bit samples fit exactly in sixteen bits, so no overflow
  always_comb begin
    sum_next = sum_reg;
    if (clr) begin
      sum_next = '0;
    end else if (add) begin
      sum_next = sum_reg + `ADCSR_RES_W'(data);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sum_reg <= '0;
    end else begin
      sum_reg <= sum_next;
    end
  end

  assign sum = sum_reg;
endmodule
`default_nettype wire

// ### adcsr_top.sv
// scan sequencer, result registers and apb slave of the converter
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "adcsr_consts.svh"
module adcsr_top (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic                           pready,
  output logic      [31:0]               prdata,
  output logic                           pslverr,
  // scan triggers
  input  wire logic                      trig_a,
  input  wire logic                      trig_b,
  // analog core
  output var adcsr_pkg::adcsr_conv_req_t conv_req,
  input  wire logic [`ADCSR_DATA_W-1:0]  conv_data,
  output logic      [2:0]                conv_ratio,
  // interrupt
  output logic                           irq
);
  localparam int NR = `ADCSR_N_RES;

  adcsr_pkg::adcsr_ctrl_t     ctrl_reg;
  adcsr_pkg::adcsr_ctrl_t     ctrl_next;
  adcsr_pkg::adcsr_ctrl_t     ctrl_wr;
  logic [`ADCSR_N_EXT-1:0]    chsa_reg;
  logic [`ADCSR_N_EXT-1:0]    chsa_next;
  logic [`ADCSR_N_EXT-1:0]    chsb_reg;
  logic [`ADCSR_N_EXT-1:0]    chsb_next;
  logic [`ADCSR_ST_W-1:0]     mask_reg;
  logic [`ADCSR_ST_W-1:0]     mask_next;
  logic [`ADCSR_ST_W-1:0]     status_reg;
  logic [`ADCSR_ST_W-1:0]     status_next;
  logic [`ADCSR_ST_W-1:0]     stat_clr;
  logic [`ADCSR_ST_W-1:0]     stat_set;
  logic                       pready_reg;
  logic                       pready_next;
  logic                       pslverr_reg;
  logic                       pslverr_next;
  logic [31:0]                prdata_reg;
  logic [31:0]                prdata_next;
  logic [31:0]                rd_val;
  logic                       rd_hit;
  logic [7:0]                 res_ofs;
  logic                       wr_take;
  logic                       sw_a;
  logic                       sw_b;
  logic                       sw_stop;
  logic                       irq_reg;
  logic                       irq_next;

  adcsr_pkg::adcsr_state_t    st_reg;
  adcsr_pkg::adcsr_state_t    st_next;
  adcsr_pkg::adcsr_conv_req_t req_reg;
  adcsr_pkg::adcsr_conv_req_t req_next;
  logic [NR-1:0]              pend_reg;
  logic [NR-1:0]              pend_next;
  logic [NR-1:0]              mask_a;
  logic [4:0]                 chan_reg;
  logic [4:0]                 chan_next;
  logic [4:0]                 low;
  logic                       grp_b_reg;
  logic                       grp_b_next;
  logic                       dbl_sec_reg;
  logic                       dbl_sec_next;
  logic [4:0]                 samp_reg;
  logic [4:0]                 samp_next;
  logic [4:0]                 need;
  logic [`ADCSR_RES_W-1:0]    res_reg [NR];
  logic [`ADCSR_RES_W-1:0]    res_next [NR];
  logic [`ADCSR_RES_W-1:0]    dup_reg;
  logic [`ADCSR_RES_W-1:0]    dup_next;
  logic [`ADCSR_RES_W-1:0]    acc_sum;
  logic                       acc_clr;
  logic                       acc_add;
  logic                       pace_start;
  logic                       pace_done;
  logic                       trig_a_all;
  logic                       trig_b_all;
  logic                       is_group;
  logic                       is_cont;
  logic                       dbl_act;
  logic                       abort;

  function automatic logic [4:0] lowest(input logic [NR-1:0] v);
    logic [4:0] r;
    r = '0;
    for (int i = NR - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  adcsr_pacer u_pacer (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (pace_start),
    .done     (pace_done)
  );

  adcsr_accum u_accum (
    .core_clk (core_clk),
    .rst      (rst),
    .clr      (acc_clr),
    .add      (acc_add),
    .data     (conv_data),
    .sum      (acc_sum)
  );

  // register read view
  always_comb begin
    rd_val  = '0;
    rd_hit  = 1'b1;
    res_ofs = paddr - `ADCSR_OFS_RES;
    case (paddr)
      `ADCSR_OFS_CTRL: rd_val = 32'(ctrl_reg);
      `ADCSR_OFS_CHSA: rd_val = 32'(chsa_reg);
      `ADCSR_OFS_CHSB: rd_val = 32'(chsb_reg);
      `ADCSR_OFS_MASK: rd_val = 32'(mask_reg);
      `ADCSR_OFS_TRIG: rd_val = '0;
      `ADCSR_OFS_DUP:  rd_val = 32'(dup_reg);
      `ADCSR_OFS_STAT: begin
        rd_val[`ADCSR_ST_W-1:0] = status_reg;
        rd_val[`ADCSR_ST_BUSY]  = st_reg != adcsr_pkg::S_IDLE;
      end
      default: begin
        // channels, then temperature, reference and self-diagnostic
        if (paddr > `ADCSR_OFS_RES - 8'h01 && paddr < `ADCSR_OFS_DUP &&
            paddr[1:0] == 2'h0) begin
          rd_val = 32'(res_reg[res_ofs[6:2]]);
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  // apb slave: one wait state, writes land on the completing edge
  always_comb begin
    ctrl_next    = ctrl_reg;
    chsa_next    = chsa_reg;
    chsb_next    = chsb_reg;
    mask_next    = mask_reg;
    pready_next  = psel & penable & ~pready_reg;
    prdata_next  = pready_next ? rd_val : prdata_reg;
    pslverr_next = pready_next & ~rd_hit;
    wr_take      = psel & penable & pready_reg & pwrite;
    ctrl_wr      = adcsr_pkg::adcsr_ctrl_t'(pwdata[`ADCSR_CTRL_W-1:0]);
    stat_clr     = '0;
    sw_a         = 1'b0;
    sw_b         = 1'b0;
    sw_stop      = 1'b0;
    if (wr_take) begin
      case (paddr)
        `ADCSR_OFS_CTRL: begin
          ctrl_next = ctrl_wr;
          // an unlisted ratio code is refused and the old ratio kept
          if (ctrl_wr.ratio > `ADCSR_RATIO_MAX) begin
            ctrl_next.ratio = ctrl_reg.ratio;
          end
        end
        `ADCSR_OFS_CHSA: chsa_next = pwdata[`ADCSR_N_EXT-1:0];
        `ADCSR_OFS_CHSB: chsb_next = pwdata[`ADCSR_N_EXT-1:0];
        `ADCSR_OFS_MASK: mask_next = pwdata[`ADCSR_ST_W-1:0];
        `ADCSR_OFS_STAT: stat_clr  = pwdata[`ADCSR_ST_W-1:0];
        `ADCSR_OFS_TRIG: begin
          sw_a    = pwdata[`ADCSR_TRIG_A];
          sw_b    = pwdata[`ADCSR_TRIG_B];
          sw_stop = pwdata[`ADCSR_TRIG_STOP];
        end
        default: ;
      endcase
    end
  end

  // scan sequencer
  always_comb begin
    trig_a_all = trig_a | sw_a;
    trig_b_all = trig_b | sw_b;
    is_group   = ctrl_reg.mode == `ADCSR_MODE_GROUP;
    is_cont    = ctrl_reg.mode == `ADCSR_MODE_CONT;
    dbl_act    = ctrl_reg.dbl_en & ~is_cont;
    mask_a     = '0;
    if (dbl_act) begin
      if (ctrl_reg.dbl_ch < 5'(`ADCSR_N_EXT)) begin
        mask_a[ctrl_reg.dbl_ch] = 1'b1;
      end
    end else if (is_group) begin
      mask_a = NR'(chsa_reg);
    end else begin
      mask_a = {ctrl_reg.diag_en, ctrl_reg.vref_en, ctrl_reg.temp_en,
                chsa_reg};
    end
    need = ~ctrl_reg.add_en ? `ADCSR_ADD_ONE :
           ctrl_reg.add_wide ? `ADCSR_ADD_FOUR : `ADCSR_ADD_TWO;
    low          = lowest(pend_reg);
    st_next      = st_reg;
    pend_next    = pend_reg;
    chan_next    = chan_reg;
    grp_b_next   = grp_b_reg;
    samp_next    = samp_reg;
    dbl_sec_next = dbl_act ? dbl_sec_reg : 1'b0;
    req_next     = '{start: 1'b0, chan: chan_reg};
    res_next     = res_reg;
    dup_next     = dup_reg;
    stat_set     = '0;
    acc_clr      = 1'b0;
    acc_add      = 1'b0;
    pace_start   = 1'b0;
    abort        = 1'b0;
    unique case (st_reg)
      adcsr_pkg::S_IDLE: begin
        if (trig_a_all) begin
          pend_next  = mask_a;
          grp_b_next = 1'b0;
          st_next    = adcsr_pkg::S_NEXT;
        end else if (trig_b_all && is_group && !dbl_act) begin
          pend_next  = NR'(chsb_reg);
          grp_b_next = 1'b1;
          st_next    = adcsr_pkg::S_NEXT;
        end
      end
      adcsr_pkg::S_NEXT: begin
        if (pend_reg == '0) begin
          stat_set[grp_b_reg ? `ADCSR_ST_DONE_B : `ADCSR_ST_DONE_A] = 1'b1;
          if (is_cont && !grp_b_reg) begin
            pend_next = mask_a;
          end else begin
            st_next = adcsr_pkg::S_IDLE;
          end
        end else begin
          chan_next      = low;
          pend_next[low] = 1'b0;
          req_next       = '{start: 1'b1, chan: low};
          samp_next      = '0;
          acc_clr        = 1'b1;
          pace_start     = 1'b1;
          st_next        = adcsr_pkg::S_WAIT;
        end
      end
      adcsr_pkg::S_WAIT: begin
        if (pace_done) begin
          acc_add   = 1'b1;
          samp_next = samp_reg + 5'h01;
          if (samp_next == need) begin
            st_next = adcsr_pkg::S_STORE;
          end else begin
            req_next   = '{start: 1'b1, chan: chan_reg};
            pace_start = 1'b1;
          end
        end
      end
      adcsr_pkg::S_STORE: begin
        if (dbl_act && dbl_sec_reg) begin
          dup_next                 = acc_sum;
          stat_set[`ADCSR_ST_DUP]  = 1'b1;
        end else begin
          res_next[chan_reg] = acc_sum;
        end
        if (dbl_act) begin
          dbl_sec_next = ~dbl_sec_reg;
        end
        st_next = adcsr_pkg::S_NEXT;
      end
    endcase
    // group A preempts B; the half-done B channel is thrown away
    if (st_reg != adcsr_pkg::S_IDLE && grp_b_reg && is_group &&
        ctrl_reg.a_prio && trig_a_all && !sw_stop) begin
      abort                     = 1'b1;
      pend_next                 = mask_a;
      grp_b_next                = 1'b0;
      req_next.start            = 1'b0;
      pace_start                = 1'b0;
      st_next                   = adcsr_pkg::S_NEXT;
      stat_set[`ADCSR_ST_ABORT] = 1'b1;
    end
    if (sw_stop) begin
      st_next        = adcsr_pkg::S_IDLE;
      pend_next      = '0;
      req_next.start = 1'b0;
    end
    // a new event beats a clear in the same cycle
    status_next = (status_reg & ~stat_clr) | stat_set;
    irq_next    = |(status_next & mask_next);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg    <= '0;
      chsa_reg    <= '0;
      chsb_reg    <= '0;
      mask_reg    <= '0;
      status_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
      irq_reg     <= 1'b0;
      st_reg      <= adcsr_pkg::S_IDLE;
      req_reg     <= '0;
      pend_reg    <= '0;
      chan_reg    <= '0;
      grp_b_reg   <= 1'b0;
      dbl_sec_reg <= 1'b0;
      samp_reg    <= '0;
      dup_reg     <= '0;
      for (int i = 0; i < NR; i++) begin
        res_reg[i] <= '0;
      end
    end else begin
      ctrl_reg    <= ctrl_next;
      chsa_reg    <= chsa_next;
      chsb_reg    <= chsb_next;
      mask_reg    <= mask_next;
      status_reg  <= status_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg  <= prdata_next;
      irq_reg     <= irq_next;
      st_reg      <= st_next;
      req_reg     <= req_next;
      pend_reg    <= pend_next;
      chan_reg    <= chan_next;
      grp_b_reg   <= grp_b_next;
      dbl_sec_reg <= dbl_sec_next;
      samp_reg    <= samp_next;
      dup_reg     <= dup_next;
      res_reg     <= res_next;
    end
  end

  assign pready     = pready_reg;
  assign prdata     = prdata_reg;
  assign pslverr    = pslverr_reg;
  assign conv_req   = req_reg;
  assign conv_ratio = ctrl_reg.ratio;
  assign irq        = irq_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_RATIO_LEGAL: assert property (conv_ratio <= `ADCSR_RATIO_MAX)
    else $error("conversion clock ratio code out of range");
  AST_CHAN_RANGE: assert property (conv_req.start |->
    conv_req.chan < 5'(`ADCSR_N_RES))
    else $error("conversion requested on a channel with no register");
  AST_SINGLE_STOP: assert property (st_reg == adcsr_pkg::S_NEXT &&
    pend_reg == '0 && ctrl_reg.mode == `ADCSR_MODE_SINGLE
    |=> st_reg == adcsr_pkg::S_IDLE)
    else $error("single scan did not stop after its last channel");
  AST_DONE_FLAG: assert property (st_reg == adcsr_pkg::S_NEXT &&
    pend_reg == '0 && !grp_b_reg |=> status_reg[`ADCSR_ST_DONE_A])
    else $error("scan complete flag not raised");
  AST_ABORT_B: assert property (abort |=> !grp_b_reg &&
    st_reg == adcsr_pkg::S_NEXT && status_reg[`ADCSR_ST_ABORT])
    else $error("group B scan not preempted by group A");
  AST_NO_DUP_CONT: assert property (st_reg == adcsr_pkg::S_STORE &&
    ctrl_reg.mode == `ADCSR_MODE_CONT |=> $stable(dup_reg))
    else $error("duplicate register written in continuous scan");
  AST_DUP_SECOND: assert property (st_reg == adcsr_pkg::S_STORE &&
    dbl_act && !dbl_sec_reg |=> $stable(dup_reg) && dbl_sec_reg)
    else $error("first double trigger result went to the duplicate");
  AST_ADD_COUNT: assert property (st_reg == adcsr_pkg::S_STORE &&
    ctrl_reg.add_en && !ctrl_reg.add_wide |-> samp_reg == 5'h04)
    else $error("addition mode summed the wrong number of samples");
  AST_STORE_12: assert property (st_reg == adcsr_pkg::S_STORE &&
    !ctrl_reg.add_en && !dbl_act |=>
    res_reg[$past(chan_reg)] == $past(acc_sum) && acc_sum[15:12] == 4'h0)
    else $error("normal result not stored as 12 bits");
  AST_IRQ: assert property (|(status_reg & mask_reg) |-> irq)
    else $error("unmasked status bit without interrupt");
  AST_PREADY: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered after one wait state");

  COV_SINGLE: cover property (st_reg == adcsr_pkg::S_NEXT && pend_reg == '0
    && ctrl_reg.mode == `ADCSR_MODE_SINGLE);
  COV_ABORT: cover property (abort);
  COV_DUP: cover property (status_reg[`ADCSR_ST_DUP]);
  COV_ADD4: cover property (st_reg == adcsr_pkg::S_STORE &&
    ctrl_reg.add_en && ctrl_reg.add_wide);
endmodule
`default_nettype wire

// ### adcsr_core_model.sv
// behavioural model of the analog conversion core
`timescale 1ns/1ns
`default_nettype none
module adcsr_core_model (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // conversion link
  input  wire adcsr_pkg::adcsr_conv_req_t conv_req,
  input  wire logic [3:0]                 bias,
  output logic      [11:0]                conv_data
);
  logic [3:0]  cnt;
  logic [11:0] val;
  logic        tog;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      val <= 12'h000;
      tog <= 1'b0;
    end else begin
      tog <= ~tog;
      if (conv_req.start) begin
        cnt <= 4'h1;
        val <= {conv_req.chan, 3'h0, bias};
      end else if (cnt != 4'h0) begin
        cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      end
    end
  end
  // valid only in the sampling cycle, so a late or early sample shows up
  assign conv_data = (cnt == 4'h8) ? val : (tog ? ~val : val ^ 12'h5A5);
endmodule
`default_nettype wire

// ### adcsr_top_tb.sv
// self-checking bench of the scan result controller
`timescale 1ns/1ns
`default_nettype none
`include "adcsr_consts.svh"
module adcsr_top_tb;
  logic                       core_clk, rst, psel, penable, pwrite;
  logic                       trig_a, trig_b, pready, pslverr, irq, e;
  logic [7:0]                 paddr;
  logic [31:0]                pwdata, prdata, q;
  logic [11:0]                conv_data;
  logic [2:0]                 conv_ratio;
  logic [3:0]                 bias;
  logic [4:0]                 pch;
  adcsr_pkg::adcsr_conv_req_t conv_req;
  int                         err_count, tests_run, nst, cyc, lst, add_chk;

  adcsr_top u_adcsr_top (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .trig_a(trig_a),
    .trig_b(trig_b), .conv_req(conv_req), .conv_data(conv_data),
    .conv_ratio(conv_ratio), .irq(irq));
  adcsr_core_model u_adcsr_core_model (.core_clk(core_clk), .rst(rst),
    .conv_req(conv_req), .bias(bias), .conv_data(conv_data));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic end_sim;
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      $display("Error t=%0t got=%h exp=%h", $time, g, x);
      err_count++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // no cycle count assumed here: only the watchdog ends a hung access
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask

  // one-cycle pulse on a trigger pin
  task automatic pin(input logic b);
    @(posedge core_clk);
    if (b) trig_b <= 1'b1;
    else trig_a <= 1'b1;
    @(posedge core_clk);
    trig_a <= 1'b0;
    trig_b <= 1'b0;
  endtask

  task automatic wait_st(input logic [31:0] m);
    int n;
    n = 0;
    do begin
      apb(1'b0, `ADCSR_OFS_STAT, 32'h0);
      n++;
    end while ((q & m) !== m && n < 100);
    chk(q & m, m);
  endtask

  function automatic logic [31:0] v(input logic [4:0] c, input logic [3:0] b);
    return {20'h0, c, 3'h0, b};
  endfunction

  always @(posedge core_clk) begin
    cyc++;
    if (conv_req.start === 1'b1) begin
      nst++;
      // eight cycles of conversion plus the cycle in which the sample is taken
      if (add_chk != 0 && pch === conv_req.chan) chk(cyc - lst, 9);
      lst = cyc;
      pch = conv_req.chan;
    end
  end

  initial begin
    #2000000;
    chk(32'h0, 32'h1);
    end_sim;
  end

  initial begin
    {rst, psel, penable, pwrite, trig_a, trig_b} = 6'h20;
    paddr = 8'h00;
    pwdata = 32'h0;
    bias = 4'h3;
    pch = 5'h1F;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd(`ADCSR_OFS_CTRL, 32'h0);
    rd(`ADCSR_OFS_STAT, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(`ADCSR_OFS_CTRL, 32'(i << 5));
      rd(`ADCSR_OFS_CTRL, 32'(i << 5));
      chk(32'(conv_ratio), 32'(i));
    end
    wr(`ADCSR_OFS_CTRL, 32'hA8);
    rd(`ADCSR_OFS_CTRL, 32'h88);
    chk(32'(conv_ratio), 32'h4);
    apb(1'b0, 8'hF0, 32'h0);
    chk(32'(e), 32'h1);
    chk(q, 32'h0);
    apb(1'b0, 8'h02, 32'h0);
    chk(32'(e), 32'h1);
    wr(`ADCSR_OFS_RES, 32'hFFFF);
    rd(`ADCSR_OFS_RES, 32'h0);
    // single scan over both ends of the channel range
    wr(`ADCSR_OFS_CTRL, 32'h0);
    wr(`ADCSR_OFS_CHSA, 32'h0080_0001);
    wr(`ADCSR_OFS_MASK, 32'h1);
    nst = 0;
    wr(`ADCSR_OFS_TRIG, 32'h1);
    wait_st(32'h1);
    rd(`ADCSR_OFS_STAT, 32'h1);
    chk(32'(irq), 32'h1);
    rd(`ADCSR_OFS_RES, v(5'd0, 4'h3));
    rd(`ADCSR_OFS_RES + 8'h5C, v(5'd23, 4'h3));
    rd(`ADCSR_OFS_RES + 8'h04, 32'h0);
    repeat (30) @(posedge core_clk);
    chk(32'(nst), 32'h2);
    wr(`ADCSR_OFS_STAT, 32'h1);
    rd(`ADCSR_OFS_STAT, 32'h0);
    chk(32'(irq), 32'h0);
    // extended inputs with the interrupt masked off
    wr(`ADCSR_OFS_MASK, 32'h0);
    bias = 4'h5;
    wr(`ADCSR_OFS_CHSA, 32'h0);
    wr(`ADCSR_OFS_CTRL, 32'h1C000);
    nst = 0;
    wr(`ADCSR_OFS_TRIG, 32'h1);
    wait_st(32'h1);
    chk(32'(irq), 32'h0);
    chk(32'(nst), 32'h3);
    rd(`ADCSR_OFS_RES + 8'h60, v(5'd24, 4'h5));
    rd(`ADCSR_OFS_RES + 8'h64, v(5'd25, 4'h5));
    rd(`ADCSR_OFS_RES + 8'h68, v(5'd26, 4'h5));
    wr(`ADCSR_OFS_STAT, 32'hF);
    // addition mode, narrow then wide, started from the pin
    wr(`ADCSR_OFS_CHSA, 32'h20);
    bias = 4'h6;
    add_chk = 1;
    for (int w = 0; w < 2; w++) begin
      wr(`ADCSR_OFS_CTRL, 32'(8 | (w << 4)));
      nst = 0;
      pch = 5'h1F;
      pin(1'b0);
      wait_st(32'h1);
      chk(32'(nst), 32'(4 << (2 * w)));
      rd(`ADCSR_OFS_RES + 8'h14, v(5'd5, 4'h6) << (2 + 2 * w));
      wr(`ADCSR_OFS_STAT, 32'h1);
    end
    add_chk = 0;
    // double trigger on channel 7
    bias = 4'h1;
    wr(`ADCSR_OFS_CTRL, 32'hE04);
    wr(`ADCSR_OFS_TRIG, 32'h1);
    wait_st(32'h1);
    rd(`ADCSR_OFS_RES + 8'h1C, v(5'd7, 4'h1));
    wr(`ADCSR_OFS_STAT, 32'hF);
    bias = 4'h2;
    wr(`ADCSR_OFS_TRIG, 32'h1);
    wait_st(32'h9);
    rd(`ADCSR_OFS_DUP, v(5'd7, 4'h2));
    rd(`ADCSR_OFS_RES + 8'h1C, v(5'd7, 4'h1));
    wr(`ADCSR_OFS_STAT, 32'hF);
    // group B refused while double trigger is on
    wr(`ADCSR_OFS_CTRL, 32'hE06);
    nst = 0;
    pin(1'b1);
    repeat (20) @(posedge core_clk);
    chk(32'(nst), 32'h0);
    // group A with priority aborts a running group B scan
    bias = 4'h9;
    wr(`ADCSR_OFS_CTRL, 32'h102);
    wr(`ADCSR_OFS_CHSB, 32'hFC00);
    wr(`ADCSR_OFS_CHSA, 32'h4);
    wr(`ADCSR_OFS_MASK, 32'h4);
    pin(1'b1);
    repeat (15) @(posedge core_clk);
    pin(1'b0);
    wait_st(32'h1);
    rd(`ADCSR_OFS_STAT, 32'h5);
    chk(32'(irq), 32'h1);
    rd(`ADCSR_OFS_RES + 8'h08, v(5'd2, 4'h9));
    rd(`ADCSR_OFS_RES + 8'h3C, 32'h0);
    // group B runs to its end on a trigger of its own
    wr(`ADCSR_OFS_STAT, 32'hF);
    pin(1'b1);
    wait_st(32'h2);
    rd(`ADCSR_OFS_STAT, 32'h2);
    rd(`ADCSR_OFS_RES + 8'h3C, v(5'd15, 4'h9));
    // continuous scan repeats its pass until software stops it
    wr(`ADCSR_OFS_CTRL, 32'h1);
    bias = 4'hA;
    wr(`ADCSR_OFS_TRIG, 32'h1);
    wait_st(32'h1);
    wr(`ADCSR_OFS_STAT, 32'h1);
    wait_st(32'h1);
    wr(`ADCSR_OFS_TRIG, 32'h4);
    apb(1'b0, `ADCSR_OFS_STAT, 32'h0);
    chk(q & 32'h100, 32'h0);
    nst = 0;
    repeat (30) @(posedge core_clk);
    chk(32'(nst), 32'h0);
    rd(`ADCSR_OFS_RES + 8'h08, v(5'd2, 4'hA));
    end_sim;
  end
endmodule
`default_nettype wire
